/* File: shared/dbrm_pkg.sv */
// package: register map, reset values and widths for the debug register bank
package dbrm_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int MAX_PAIRS = 16;
  // register offsets (byte addresses)
  localparam logic [11:0] OFS_DBG_ID = 12'h000;
  localparam logic [11:0] OFS_WATCH_FAULT = 12'h018;
  localparam logic [11:0] OFS_VEC_CATCH = 12'h01c;
  localparam logic [11:0] OFS_EVT_CATCH = 12'h024;
  localparam logic [11:0] OFS_HALT_CACHE = 12'h028;
  localparam logic [11:0] OFS_HALT_MMU = 12'h02c;
  localparam logic [11:0] OFS_H2T_DATA = 12'h080;
  localparam logic [11:0] OFS_INSTR_XFER = 12'h084;
  localparam logic [11:0] OFS_STAT_CTRL = 12'h088;
  localparam logic [11:0] OFS_T2H_DATA = 12'h08c;
  localparam logic [11:0] OFS_RUN_CTRL = 12'h090;
  localparam logic [11:0] OFS_BKPT_VAL = 12'h100;
  localparam logic [11:0] OFS_BKPT_CTL = 12'h140;
  localparam logic [11:0] OFS_WATCH_VAL = 12'h180;
  localparam logic [11:0] OFS_WATCH_CTL = 12'h1c0;
  localparam logic [11:0] OFS_OS_LOCK_KEY = 12'h300;
  localparam logic [11:0] OFS_OS_LOCK_STATE = 12'h304;
  localparam logic [11:0] OFS_OS_SAVE = 12'h308;
  localparam logic [11:0] OFS_PD_CTRL = 12'h310;
  localparam logic [11:0] OFS_PD_STATE = 12'h314;
  localparam logic [11:0] OFS_MGMT_LO = 12'hd00;
  localparam logic [11:0] OFS_MGMT_HI = 12'hffc;
  // array slot field and group size
  localparam int SLOT_LSB = 2;
  localparam int SLOT_W = 4;
  localparam logic [11:0] ARRAY_MASK = 12'hfc0;
  // coprocessor-only register numbers (no memory offset)
  localparam logic [9:0] CP_ROM_ADDR = 10'h3fe;
  localparam logic [9:0] CP_SELF_OFS = 10'h3ff;
  localparam logic [31:0] OS_LOCK_KEY = 32'hc5acce55;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [31:0] OS_SAVE_COUNT = 32'h0000_0000;
  localparam int LOCK_BIT = 1;
  localparam int LOCK_IMPL_BIT = 0;
  // access path
  typedef enum logic [1:0] {
    DBRM_IDLE = 2'b01,
    DBRM_ACK = 2'b10
  } dbrm_state_e;
endpackage

/* File: shared/dbrm_arr_if.sv */
// interface: access port of the breakpoint/watchpoint array store
`timescale 1ns/1ns
interface dbrm_arr_if;
  logic wr_en;
  logic [5:0] wr_idx;
  logic [5:0] rd_idx;
  logic [31:0] wr_data;
  logic [31:0] rd_data;
  modport ctrl (output wr_en, output wr_idx, output rd_idx,
    output wr_data, input rd_data);
  modport store (input wr_en, input wr_idx, input rd_idx,
    input wr_data, output rd_data);
endinterface

/* File: hw/dbrm_arr_mem.sv */
// memory: breakpoint and watchpoint value/control words, registered read
`timescale 1ns/1ns
module dbrm_arr_mem #(
  parameter int DEPTH = 64
) (
  // clock and debug reset
  input wire logic core_clk,
  input wire logic dbg_rst,
  // access port
  dbrm_arr_if.store port
);
  logic [31:0] mem [DEPTH];

  // write port and clear on any debug-logic reset
  always_ff @(posedge core_clk or posedge dbg_rst) begin
    if (dbg_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= dbrm_pkg::ZERO_WORD;
      end
    end else if (port.wr_en) begin
      mem[port.wr_idx] <= port.wr_data;
    end
  end

  // registered read data
  always_ff @(posedge core_clk or posedge dbg_rst) begin
    if (dbg_rst) begin
      port.rd_data <= dbrm_pkg::ZERO_WORD;
    end else begin
      port.rd_data <= mem[port.rd_idx];
    end
  end
endmodule

/* File: hw/dbrm_top.sv */
// top: debug register bank with map decode and four-way reset scheme
`timescale 1ns/1ns
module dbrm_top #(
  parameter int NUM_BKPT = 16,
  parameter int NUM_WATCH = 16,
  parameter logic [31:0] ID_VALUE = 32'h0001_0000, // arbitrary value
  parameter logic [31:0] ROM_ADDR_VALUE = 32'h0000_0000,
  parameter logic [31:0] SELF_OFS_VALUE = 32'h0000_0000
) (
  // clock and the four active-low resets
  input wire logic core_clk,
  input wire logic rst,
  input wire logic system_power_on_rst_n,
  input wire logic core_power_on_rst_n,
  input wire logic warm_soft_rst_n,
  input wire logic debug_logic_rst_n,
  // memory-mapped register access
  input wire logic mm_req,
  input wire logic mm_write,
  input wire logic [11:0] mm_addr,
  input wire logic [31:0] mm_wdata,
  output logic mm_ack,
  output logic [31:0] mm_rdata,
  // coprocessor register access, by register number
  input wire logic cp_req,
  input wire logic cp_write,
  input wire logic [9:0] cp_regnum,
  input wire logic [31:0] cp_wdata,
  output logic cp_ack,
  output logic [31:0] cp_rdata,
  // core side
  input wire logic [31:0] pc_sample,
  output logic [31:0] instr_word,
  output logic instr_valid,
  output logic [31:0] run_ctrl_word,
  output logic run_ctrl_valid,
  output logic core_logic_rst
);
  // elaboration check on pair counts
  if (NUM_BKPT < 1 || NUM_BKPT > dbrm_pkg::MAX_PAIRS ||
      NUM_WATCH < 1 || NUM_WATCH > dbrm_pkg::MAX_PAIRS) begin : g_bad
    $error("pair count out of range");
  end

  // reset domains; debug domain on system power-on or debug reset
  logic dbgdom_rst;
  logic coredbg_rst;
  logic nondbg_rst;
  assign dbgdom_rst = rst | ~system_power_on_rst_n | ~debug_logic_rst_n;
  assign coredbg_rst = dbgdom_rst | ~core_power_on_rst_n;
  assign nondbg_rst = rst | ~system_power_on_rst_n | ~core_power_on_rst_n |
    ~warm_soft_rst_n;

  // local constants: array span, sequence counter steps, store depth
  localparam logic [11:0] SLOT_SPAN = 12'h03c;
  localparam logic [7:0] SEQ_START = 8'h00;
  localparam logic [7:0] SEQ_STEP = 8'h01;
  localparam int ARR_DEPTH = 64;
  if (ARR_DEPTH < 4 * dbrm_pkg::MAX_PAIRS) begin : g_bad_depth
    $error("array store too shallow");
  end

  // slot decode, used by both access paths
  function automatic logic slot_ok(input logic [11:0] a, input int num);
    logic [11:0] base;
    base = a & dbrm_pkg::ARRAY_MASK;
    slot_ok = (base == dbrm_pkg::OFS_BKPT_VAL || base == dbrm_pkg::OFS_BKPT_CTL)
      ? (int'(a[dbrm_pkg::SLOT_LSB +: dbrm_pkg::SLOT_W]) < NUM_BKPT)
      : (int'(a[dbrm_pkg::SLOT_LSB +: dbrm_pkg::SLOT_W]) < num);
  endfunction

  function automatic logic in_array(input logic [11:0] a);
    in_array = a >= dbrm_pkg::OFS_BKPT_VAL &&
      a <= (dbrm_pkg::OFS_WATCH_CTL | SLOT_SPAN);
  endfunction

  // access sequencer state, declared early for the take condition
  dbrm_pkg::dbrm_state_e state;
  logic pend_cp;
  logic pend_arr;
  logic [31:0] pend_data;

  // arbiter: coprocessor path wins; taken only while the sequencer idles
  logic sel_cp;
  logic req_any;
  logic is_wr;
  logic [11:0] addr;
  logic [31:0] wdata;
  assign sel_cp = cp_req;
  assign req_any = (cp_req | mm_req) & ~mm_ack & ~cp_ack &
    (state == dbrm_pkg::DBRM_IDLE);
  assign is_wr = sel_cp ? cp_write : mm_write;
  assign addr = sel_cp ? {cp_regnum, 2'b00} : {mm_addr[11:2], 2'b00};
  assign wdata = sel_cp ? cp_wdata : mm_wdata;

  // register write strobe, not qualified by address; each register decodes addr itself
  logic wr_hit;
  assign wr_hit = req_any & is_wr;

  // strobes for the two transfer registers toward the core
  logic instr_hit;
  logic run_hit;
  assign instr_hit = wr_hit && addr == dbrm_pkg::OFS_INSTR_XFER;
  assign run_hit = wr_hit && addr == dbrm_pkg::OFS_RUN_CTRL;

  // debug-domain registers
  logic [31:0] evt_catch;
  logic [31:0] pd_ctrl;
  logic [31:0] pd_state;
  logic os_locked;
  logic [7:0] os_seq;
  // core-domain debug registers
  logic [31:0] watch_fault;
  logic [31:0] vec_catch;
  logic [31:0] halt_cache;
  logic [31:0] halt_mmu;
  logic [31:0] h2t_data;
  logic [31:0] stat_ctrl;
  logic [31:0] t2h_data;

  // event catch, power-down control and status in the debug domain
  always_ff @(posedge core_clk or posedge dbgdom_rst) begin
    if (dbgdom_rst) begin
      evt_catch <= dbrm_pkg::ZERO_WORD;
      pd_ctrl <= dbrm_pkg::ZERO_WORD;
      pd_state <= dbrm_pkg::ZERO_WORD;
    end else if (wr_hit) begin
      if (addr == dbrm_pkg::OFS_EVT_CATCH) evt_catch <= wdata;
      if (addr == dbrm_pkg::OFS_PD_CTRL) pd_ctrl <= wdata;
      if (addr == dbrm_pkg::OFS_PD_STATE) pd_state <= wdata;
    end
  end

  // os lock flag, set by the key and cleared by any other value
  always_ff @(posedge core_clk or posedge dbgdom_rst) begin
    if (dbgdom_rst) begin
      os_locked <= 1'b0;
    end else if (wr_hit && addr == dbrm_pkg::OFS_OS_LOCK_KEY) begin
      os_locked <= (wdata == dbrm_pkg::OS_LOCK_KEY);
    end
  end

  // save/restore sequence counter; a lock key write restarts it
  always_ff @(posedge core_clk or posedge dbgdom_rst) begin
    if (dbgdom_rst) begin
      os_seq <= SEQ_START;
    end else if (wr_hit && addr == dbrm_pkg::OFS_OS_LOCK_KEY) begin
      os_seq <= SEQ_START;
    end else if (req_any && addr == dbrm_pkg::OFS_OS_SAVE) begin
      os_seq <= os_seq + SEQ_STEP;
    end
  end

  // core-domain debug registers; external views alias internal ones
  always_ff @(posedge core_clk or posedge coredbg_rst) begin
    if (coredbg_rst) begin
      watch_fault <= dbrm_pkg::ZERO_WORD;
      vec_catch <= dbrm_pkg::ZERO_WORD;
      halt_cache <= dbrm_pkg::ZERO_WORD;
      halt_mmu <= dbrm_pkg::ZERO_WORD;
      h2t_data <= dbrm_pkg::ZERO_WORD;
      stat_ctrl <= dbrm_pkg::ZERO_WORD;
      t2h_data <= dbrm_pkg::ZERO_WORD;
    end else if (wr_hit) begin
      if (addr == dbrm_pkg::OFS_WATCH_FAULT) watch_fault <= wdata;
      if (addr == dbrm_pkg::OFS_VEC_CATCH) vec_catch <= wdata;
      if (addr == dbrm_pkg::OFS_HALT_CACHE) halt_cache <= wdata;
      if (addr == dbrm_pkg::OFS_HALT_MMU) halt_mmu <= wdata;
      if (addr == dbrm_pkg::OFS_H2T_DATA) h2t_data <= wdata;
      if (addr == dbrm_pkg::OFS_STAT_CTRL) stat_ctrl <= wdata;
      if (addr == dbrm_pkg::OFS_T2H_DATA) t2h_data <= wdata;
    end
  end

  // array store for breakpoints and watchpoints
  dbrm_arr_if arr ();
  logic arr_hit;
  assign arr_hit = in_array(addr) && slot_ok(addr, NUM_WATCH);
  assign arr.wr_en = wr_hit & arr_hit;
  assign arr.wr_idx = addr[7:2];
  assign arr.rd_idx = addr[7:2];
  assign arr.wr_data = wdata;

  dbrm_arr_mem #(
    .DEPTH(ARR_DEPTH)
  ) u_arr (
    .core_clk(core_clk),
    .dbg_rst(dbgdom_rst),
    .port(arr.store)
  );

  // read mux for the plain registers
  logic [31:0] next_rdata;
  logic next_from_arr;
  always_comb begin
    next_rdata = dbrm_pkg::ZERO_WORD;
    next_from_arr = 1'b0;
    if (sel_cp && cp_regnum == dbrm_pkg::CP_ROM_ADDR) begin
      next_rdata = ROM_ADDR_VALUE;
    end else if (sel_cp && cp_regnum == dbrm_pkg::CP_SELF_OFS) begin
      next_rdata = SELF_OFS_VALUE;
    end else if (addr >= dbrm_pkg::OFS_MGMT_LO &&
                 addr <= dbrm_pkg::OFS_MGMT_HI) begin
      next_rdata = dbrm_pkg::ZERO_WORD;
    end else if (in_array(addr)) begin
      next_from_arr = arr_hit;
    end else begin
      unique case (addr)
        dbrm_pkg::OFS_DBG_ID: next_rdata = ID_VALUE;
        dbrm_pkg::OFS_WATCH_FAULT: next_rdata = watch_fault;
        dbrm_pkg::OFS_VEC_CATCH: next_rdata = vec_catch;
        dbrm_pkg::OFS_EVT_CATCH: next_rdata = evt_catch;
        dbrm_pkg::OFS_HALT_CACHE: next_rdata = halt_cache;
        dbrm_pkg::OFS_HALT_MMU: next_rdata = halt_mmu;
        dbrm_pkg::OFS_H2T_DATA: next_rdata = h2t_data;
        dbrm_pkg::OFS_INSTR_XFER: next_rdata = pc_sample;
        dbrm_pkg::OFS_STAT_CTRL: next_rdata = stat_ctrl;
        dbrm_pkg::OFS_T2H_DATA: next_rdata = t2h_data;
        dbrm_pkg::OFS_RUN_CTRL: next_rdata = dbrm_pkg::ZERO_WORD;
        dbrm_pkg::OFS_OS_LOCK_KEY: next_rdata = dbrm_pkg::ZERO_WORD;
        dbrm_pkg::OFS_OS_LOCK_STATE: begin
          next_rdata = dbrm_pkg::ZERO_WORD;
          next_rdata[dbrm_pkg::LOCK_BIT] = os_locked;
          next_rdata[dbrm_pkg::LOCK_IMPL_BIT] = 1'b1;
        end
        dbrm_pkg::OFS_OS_SAVE: next_rdata = (os_seq == SEQ_START) ?
          dbrm_pkg::OS_SAVE_COUNT : dbrm_pkg::ZERO_WORD;
        dbrm_pkg::OFS_PD_CTRL: next_rdata = pd_ctrl;
        dbrm_pkg::OFS_PD_STATE: next_rdata = pd_state;
        default: next_rdata = dbrm_pkg::ZERO_WORD;
      endcase
    end
  end

  // two-state access sequencer; array reads need the extra cycle
  always_ff @(posedge core_clk or posedge dbgdom_rst) begin
    if (dbgdom_rst) begin
      state <= dbrm_pkg::DBRM_IDLE;
      pend_cp <= 1'b0;
      pend_arr <= 1'b0;
      pend_data <= dbrm_pkg::ZERO_WORD;
    end else begin
      unique case (state)
        dbrm_pkg::DBRM_IDLE: begin
          if (req_any) begin
            state <= dbrm_pkg::DBRM_ACK;
            pend_cp <= sel_cp;
            pend_arr <= next_from_arr & ~is_wr;
            pend_data <= is_wr ? dbrm_pkg::ZERO_WORD : next_rdata;
          end
        end
        dbrm_pkg::DBRM_ACK: begin
          state <= dbrm_pkg::DBRM_IDLE;
        end
        default: state <= dbrm_pkg::DBRM_IDLE;
      endcase
    end
  end

  // memory-mapped answer port, registered
  always_ff @(posedge core_clk or posedge dbgdom_rst) begin
    if (dbgdom_rst) begin
      mm_ack <= 1'b0;
      mm_rdata <= dbrm_pkg::ZERO_WORD;
    end else begin
      mm_ack <= (state == dbrm_pkg::DBRM_ACK) & ~pend_cp;
      if (state == dbrm_pkg::DBRM_ACK) begin
        mm_rdata <= pend_cp ? dbrm_pkg::ZERO_WORD :
          (pend_arr ? arr.rd_data : pend_data);
      end
    end
  end

  // coprocessor answer port, registered
  always_ff @(posedge core_clk or posedge dbgdom_rst) begin
    if (dbgdom_rst) begin
      cp_ack <= 1'b0;
      cp_rdata <= dbrm_pkg::ZERO_WORD;
    end else begin
      cp_ack <= (state == dbrm_pkg::DBRM_ACK) & pend_cp;
      if (state == dbrm_pkg::DBRM_ACK) begin
        cp_rdata <= pend_cp ? (pend_arr ? arr.rd_data : pend_data) :
          dbrm_pkg::ZERO_WORD;
      end
    end
  end

  // instruction transfer strobe and word toward the core
  always_ff @(posedge core_clk or posedge coredbg_rst) begin
    if (coredbg_rst) begin
      instr_word <= dbrm_pkg::ZERO_WORD;
      instr_valid <= 1'b0;
    end else begin
      instr_valid <= instr_hit;
      if (instr_hit) begin
        instr_word <= wdata;
      end
    end
  end

  // run control strobe and word toward the core
  always_ff @(posedge core_clk or posedge coredbg_rst) begin
    if (coredbg_rst) begin
      run_ctrl_word <= dbrm_pkg::ZERO_WORD;
      run_ctrl_valid <= 1'b0;
    end else begin
      run_ctrl_valid <= run_hit;
      if (run_hit) begin
        run_ctrl_word <= wdata;
      end
    end
  end

  // registered non-debug reset toward the core; soft reset reaches only here
  always_ff @(posedge core_clk or posedge nondbg_rst) begin
    if (nondbg_rst) begin
      core_logic_rst <= 1'b1;
    end else begin
      core_logic_rst <= 1'b0;
    end
  end
endmodule

/* File: dv/dbrm_monitor.sv */
// checker: reset and answer relations at the register bank ports
`timescale 1ns/1ns
module dbrm_monitor (
  // clock and resets
  input wire logic core_clk,
  input wire logic rst,
  input wire logic system_power_on_rst_n,
  input wire logic core_power_on_rst_n,
  input wire logic warm_soft_rst_n,
  input wire logic debug_logic_rst_n,
  // memory-mapped side
  input wire logic mm_req,
  input wire logic mm_write,
  input wire logic [11:0] mm_addr,
  input wire logic [31:0] mm_wdata,
  input wire logic mm_ack,
  input wire logic [31:0] mm_rdata,
  // coprocessor side
  input wire logic cp_req,
  input wire logic cp_write,
  input wire logic [9:0] cp_regnum,
  input wire logic [31:0] cp_wdata,
  input wire logic cp_ack,
  input wire logic [31:0] cp_rdata,
  // core side
  input wire logic [31:0] pc_sample,
  input wire logic [31:0] instr_word,
  input wire logic instr_valid,
  input wire logic [31:0] run_ctrl_word,
  input wire logic run_ctrl_valid,
  input wire logic core_logic_rst
);
  // register numbers of the two transfer strobes
  localparam logic [9:0] INSTR_NUM = 10'h021;
  localparam logic [9:0] RUN_NUM = 10'h024;
  logic nondbg_free;
  logic [9:0] mm_num;
  logic [31:0] req_wdata;
  logic instr_wr;
  logic run_wr;
  logic pc_rd;
  // request as the bank takes it: coprocessor path first
  assign nondbg_free = system_power_on_rst_n & core_power_on_rst_n &
    warm_soft_rst_n;
  assign mm_num = mm_addr[11:2];
  assign req_wdata = cp_req ? cp_wdata : mm_wdata;
  assign instr_wr = cp_req ? (cp_write && cp_regnum == INSTR_NUM) :
    (mm_req && mm_write && mm_num == INSTR_NUM);
  assign run_wr = cp_req ? (cp_write && cp_regnum == RUN_NUM) :
    (mm_req && mm_write && mm_num == RUN_NUM);
  assign pc_rd = !cp_req && mm_req && !mm_write && mm_num == INSTR_NUM;
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // reset effects on answers and on the core reset output
  a_dbg_quiet: assert property (!debug_logic_rst_n |->
    !mm_ack && !cp_ack && mm_rdata == 32'h0 && cp_rdata == 32'h0)
    else $error("answer active in debug reset");
  a_sys_core_rst: assert property (!system_power_on_rst_n |->
    core_logic_rst) else $error("core logic free in system reset");
  a_corepor_rst: assert property (!core_power_on_rst_n |->
    core_logic_rst) else $error("core logic free in core reset");
  a_soft_core_rst: assert property (!warm_soft_rst_n |->
    core_logic_rst) else $error("core logic free in soft reset");
  a_dbg_keeps_core: assert property (nondbg_free ##1 nondbg_free |->
    !core_logic_rst) else $error("core logic held without its reset");
  // transfer strobes follow one write each and carry its data
  a_instr_from_wr: assert property (instr_valid |->
    $past(instr_wr) && instr_word == $past(req_wdata))
    else $error("instruction strobe without a write");
  a_instr_single: assert property (instr_valid |=> !instr_valid)
    else $error("instruction strobe too long");
  a_run_from_wr: assert property (run_ctrl_valid |->
    $past(run_wr) && run_ctrl_word == $past(req_wdata))
    else $error("run control strobe without a write");
  a_pc_readback: assert property ($past(pc_rd, 2) && mm_ack |->
    mm_rdata == $past(pc_sample, 2)) else $error("pc sample read wrong");
endmodule

// attach the checker to the bank, port by port
bind dbrm_top dbrm_monitor dbrm_monitor_inst (
  .core_clk(core_clk),
  .rst(rst),
  .system_power_on_rst_n(system_power_on_rst_n),
  .core_power_on_rst_n(core_power_on_rst_n),
  .warm_soft_rst_n(warm_soft_rst_n),
  .debug_logic_rst_n(debug_logic_rst_n),
  .mm_req(mm_req),
  .mm_write(mm_write),
  .mm_addr(mm_addr),
  .mm_wdata(mm_wdata),
  .mm_ack(mm_ack),
  .mm_rdata(mm_rdata),
  .cp_req(cp_req),
  .cp_write(cp_write),
  .cp_regnum(cp_regnum),
  .cp_wdata(cp_wdata),
  .cp_ack(cp_ack),
  .cp_rdata(cp_rdata),
  .pc_sample(pc_sample),
  .instr_word(instr_word),
  .instr_valid(instr_valid),
  .run_ctrl_word(run_ctrl_word),
  .run_ctrl_valid(run_ctrl_valid),
  .core_logic_rst(core_logic_rst)
);

/* File: dv/dbrm_rst_partner.sv */
// partner: reset and power controller driving the four reset lines
`timescale 1ns/1ns
module dbrm_rst_partner #(
  parameter int HOLD = 3
) (
  // clock and requests: 0 system, 1 core, 2 soft, 3 debug
  input wire logic core_clk,
  input wire logic [3:0] pulse_req,
  // reset lines
  output logic system_power_on_rst_n,
  output logic core_power_on_rst_n,
  output logic warm_soft_rst_n,
  output logic debug_logic_rst_n
);
  int cnt [4] = '{HOLD, 0, 0, 0};
  // system reset low from power-up; a request holds its line low HOLD cycles
  always @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (pulse_req[i]) begin
        cnt[i] <= HOLD;
      end else if (cnt[i] > 0) begin
        cnt[i] <= cnt[i] - 1;
      end
    end
  end
  // a line stays low while its count runs
  assign system_power_on_rst_n = (cnt[0] == 0);
  assign core_power_on_rst_n = (cnt[1] == 0);
  assign warm_soft_rst_n = (cnt[2] == 0);
  assign debug_logic_rst_n = (cnt[3] == 0);
endmodule

/* File: dv/tb_top.sv */
// testbench: model-checked register accesses and reset effects
`timescale 1ns/1ns
module tb_top;
  localparam int NB = 4;
  localparam int NW = 2;
  localparam logic [31:0] ID_V = 32'h0000_1234; // arbitrary value
  localparam logic [31:0] ROM_V = 32'h0000_4000;
  localparam logic [31:0] SELF_V = 32'h0000_0100;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] pulse_req = 4'h0;
  logic system_power_on_rst_n, core_power_on_rst_n;
  logic warm_soft_rst_n, debug_logic_rst_n;
  logic mm_req = 1'b0, mm_write = 1'b0, cp_req = 1'b0, cp_write = 1'b0;
  logic [11:0] mm_addr = 12'h000;
  logic [9:0] cp_regnum = 10'h000;
  logic [31:0] mm_wdata = 32'h0, cp_wdata = 32'h0, pc_sample = 32'h0;
  logic mm_ack, cp_ack, instr_valid, run_ctrl_valid, core_logic_rst;
  logic [31:0] mm_rdata, cp_rdata, instr_word, run_ctrl_word;
  logic [31:0] seed = 32'h0000_003f;
  logic [31:0] mdl [int];
  logic [31:0] q, d, got_i, got_r;
  int miscompares = 0, total_checks = 0, n_i = 0, n_r = 0;
  logic [11:0] rw_l [10] = '{12'h018, 12'h01c, 12'h028, 12'h02c, 12'h080,
    12'h088, 12'h08c, 12'h024, 12'h310, 12'h314};
  logic [11:0] rsv [10] = '{12'h004, 12'h020, 12'h030, 12'h0c0, 12'h200,
    12'h30c, 12'h318, 12'hd00, 12'hf00, 12'hffc};
  // reset controller and the bank
  dbrm_rst_partner dbrm_rst_partner_inst (.core_clk, .pulse_req,
    .system_power_on_rst_n, .core_power_on_rst_n, .warm_soft_rst_n,
    .debug_logic_rst_n);
  dbrm_top #(.NUM_BKPT(NB), .NUM_WATCH(NW), .ID_VALUE(ID_V),
    .ROM_ADDR_VALUE(ROM_V), .SELF_OFS_VALUE(SELF_V)) dbrm_top_inst (
    .core_clk, .rst, .system_power_on_rst_n, .core_power_on_rst_n,
    .warm_soft_rst_n, .debug_logic_rst_n, .mm_req, .mm_write, .mm_addr,
    .mm_wdata, .mm_ack, .mm_rdata, .cp_req, .cp_write, .cp_regnum,
    .cp_wdata, .cp_ack, .cp_rdata, .pc_sample, .instr_word, .instr_valid,
    .run_ctrl_word, .run_ctrl_valid, .core_logic_rst);
  // 100 ns clock
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  // latch every transfer pulse toward the core
  always @(posedge core_clk) begin
    if (instr_valid === 1'b1) begin
      got_i <= instr_word;
      n_i <= n_i + 1;
    end
    if (run_ctrl_valid === 1'b1) begin
      got_r <= run_ctrl_word;
      n_r <= n_r + 1;
    end
  end
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic [31:0] ex(input logic [11:0] a);
    return mdl.exists(int'(a[11:2])) ? mdl[int'(a[11:2])] : 32'h0;
  endfunction
  task print_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  // one access on either path, held until its ack is sampled
  task acc(input logic c, input logic w, input logic [11:0] a,
    input logic [31:0] dv, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    #1;
    cp_req = c;
    cp_write = w;
    cp_regnum = a[11:2];
    cp_wdata = dv;
    mm_req = !c;
    mm_write = w;
    mm_addr = a;
    mm_wdata = dv;
    do begin
      @(posedge core_clk);
      n++;
    end while ((c ? cp_ack : mm_ack) !== 1'b1 && n < 20);
    r = c ? cp_rdata : mm_rdata;
    if (n >= 20) begin
      miscompares++;
      $display("[FAIL] %0t no ack", $time);
      print_verdict();
    end else begin
      #1;
      cp_req = 1'b0;
      mm_req = 1'b0;
    end
  endtask
  // pulse one reset line and look at the core reset output
  task rpulse(input int i, input logic e);
    @(posedge core_clk);
    #1 pulse_req[i] = 1'b1;
    @(posedge core_clk);
    #1 pulse_req[i] = 1'b0;
    chk({31'h0, core_logic_rst}, {31'h0, e});
    repeat (5) @(posedge core_clk);
    #1 chk({31'h0, core_logic_rst}, 32'h0);
  endtask
  // write the plain registers through alternating paths and all array slots through the coprocessor path
  task fill();
    for (int i = 0; i < 10; i++) begin
      d = rnd();
      acc(!i[0], 1'b1, rw_l[i], d, q);
      mdl[int'(rw_l[i][11:2])] = d;
    end
    for (int a = 'h100; a < 'h200; a += 4) begin
      d = rnd();
      acc(1'b1, 1'b1, a[11:0], d, q);
      if (((a >> 2) & 15) < (a < 'h180 ? NB : NW)) mdl[a >> 2] = d;
    end
  endtask
  // read everything back and compare with the model
  task sweep();
    for (int i = 0; i < 10; i++) begin
      acc(i[0], 1'b0, rw_l[i], 32'h0, q);
      chk(q, ex(rw_l[i]));
    end
    for (int a = 'h100; a < 'h200; a += 4) begin
      acc(1'b0, 1'b0, a[11:0], 32'h0, q);
      chk(q, ex(a[11:0]));
    end
  endtask
  // main sequence
  initial begin
    pc_sample = rnd();
    repeat (4) @(posedge core_clk);
    #1 rst = 1'b0;
    acc(1'b0, 1'b0, 12'h000, 32'h0, q);
    chk(q, ID_V);
    sweep();
    fill();
    sweep();
    d = rnd();
    acc(1'b0, 1'b1, 12'h084, d, q);
    @(posedge core_clk);
    #1 chk(n_i, 1);
    chk(got_i, d);
    acc(1'b0, 1'b0, 12'h084, 32'h0, q);
    chk(q, pc_sample);
    d = rnd();
    acc(1'b1, 1'b1, 12'h090, d, q);
    @(posedge core_clk);
    #1 chk(n_r, 1);
    chk(got_r, d);
    acc(1'b0, 1'b0, 12'h090, 32'h0, q);
    chk(q, 32'h0);
    acc(1'b0, 1'b1, 12'h300, 32'hc5ac_ce55, q);
    acc(1'b0, 1'b0, 12'h304, 32'h0, q);
    chk(q, 32'h3);
    acc(1'b0, 1'b0, 12'h308, 32'h0, q);
    chk(q, 32'h0);
    acc(1'b0, 1'b1, 12'h304, rnd(), q);
    acc(1'b1, 1'b0, 12'h304, 32'h0, q);
    chk(q, 32'h3);
    acc(1'b0, 1'b1, 12'h300, rnd(), q);
    acc(1'b0, 1'b0, 12'h304, 32'h0, q);
    chk(q, 32'h1);
    for (int i = 0; i < 10; i++) begin
      acc(1'b0, 1'b1, rsv[i], rnd(), q);
      acc(1'b0, 1'b0, rsv[i], 32'h0, q);
      chk(q, 32'h0);
    end
    acc(1'b1, 1'b0, 12'hff8, 32'h0, q);
    chk(q, ROM_V);
    acc(1'b1, 1'b0, 12'hffc, 32'h0, q);
    chk(q, SELF_V);
    rpulse(2, 1'b1);
    sweep();
    rpulse(1, 1'b1);
    for (int i = 0; i < 7; i++) mdl.delete(int'(rw_l[i][11:2]));
    sweep();
    rpulse(3, 1'b0);
    mdl.delete();
    sweep();
    fill();
    rpulse(0, 1'b1);
    mdl.delete();
    sweep();
    print_verdict();
  end
endmodule
